// ===== logic/discrete_io_pkg.sv
// Shared constants, register map and state codes for the discrete I/O block
package discrete_io_pkg;
    // Data widths
    localparam int MEAS_W  = 32;
    localparam int HEAD_W  = 8;
    localparam int NUM_IN  = 4;

    // Register byte offsets on the APB port
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] UPPER_OFS  = 8'h04;
    localparam logic [7:0] LOWER_OFS  = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] HELD_OFS   = 8'h10;
    localparam logic [7:0] ZERO_OFS   = 8'h14;

    // Control register fields
    localparam int CTRL_BANK_MODE_BIT = 0;
    localparam int CTRL_HOLD_EN_BIT   = 1;
    localparam int CTRL_NM_KEEP_BIT   = 2;
    localparam int CTRL_W             = 3;

    // Status register fields
    localparam int ST_HIGH_BIT     = 0;
    localparam int ST_PASS_BIT     = 1;
    localparam int ST_LOW_BIT      = 2;
    localparam int ST_READY_BIT    = 3;
    localparam int ST_BUSY_BIT     = 4;
    localparam int ST_LIGHT_ERR    = 5;
    localparam int ST_ZERO_ACT_BIT = 6;
    localparam int ST_HOLD_VAL_BIT = 7;
    localparam int ST_BANK_LSB     = 8;
    localparam int ST_HEAD_CHG_BIT = 10;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 3'h0;
    localparam logic [MEAS_W-1:0] UPPER_RST = 32'h7FFF_FFFF;
    localparam logic [MEAS_W-1:0] LOWER_RST = 32'h8000_0000;

    // Input pin positions
    localparam int IN_TRIG_BANK_A = 0;
    localparam int IN_RESET_BANK_B = 1;
    localparam int IN_LASER_OFF   = 2;
    localparam int IN_ZERO        = 3;

    // Timing: busy time of a bank switch
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int BANK_SW_NS     = 1000;
    localparam int BANK_SW_W      = 8;
    localparam logic [BANK_SW_W-1:0] BANK_SW_CYCLES =
        BANK_SW_W'((BANK_SW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Hold sequencer states
    typedef enum logic [2:0] {
        HOLD_IDLE   = 3'b001,
        HOLD_SAMPLE = 3'b010,
        HOLD_HELD   = 3'b100
    } hold_state_t;
endpackage

// ===== logic/judge_if.sv
// Carrier between the control core and the threshold comparator
`timescale 1ns/1ps
interface judge_if;
    import discrete_io_pkg::*;
    logic signed [MEAS_W-1:0] value;
    logic signed [MEAS_W-1:0] upper;
    logic signed [MEAS_W-1:0] lower;
    logic                     high;
    logic                     pass;
    logic                     low;
    modport ctrl (output value, output upper, output lower,
                  input high, input pass, input low);
    modport cmp  (input value, input upper, input lower,
                  output high, output pass, output low);
endinterface

// ===== logic/input_conditioner.sv
// Two-stage synchroniser and edge detector for each control input
`timescale 1ns/1ps
module input_conditioner
    import discrete_io_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [NUM_IN-1:0] raw_i,
    output logic      [NUM_IN-1:0] level_o,
    output logic      [NUM_IN-1:0] rise_o,
    output logic      [NUM_IN-1:0] fall_o
);
    import discrete_io_pkg::*;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            logic meta_q, sync_q, prev_q;
            logic meta_d, sync_d, prev_d;
            // First stage feeds only the second stage
            always_comb begin
                meta_d = raw_i[gi];
                sync_d = meta_q;
                prev_d = sync_q;
            end
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= meta_d;
                    sync_q <= sync_d;
                    prev_q <= prev_d;
                end
            end
            // Edges compare the settled stage with its delayed copy
            assign level_o[gi] = sync_q;
            assign rise_o[gi]  = sync_q & ~prev_q;
            assign fall_o[gi]  = ~sync_q & prev_q;
        end
    endgenerate
endmodule

// ===== logic/threshold_judge.sv
// Signed three-way comparison of a value against two limits
`timescale 1ns/1ps
module threshold_judge
    import discrete_io_pkg::*;
(
    judge_if.cmp jif
);
    import discrete_io_pkg::*;

    // Limits are inclusive for pass; high and low are strict
    always_comb begin
        jif.high = jif.value > jif.upper;
        jif.low  = jif.value < jif.lower;
        jif.pass = (jif.value >= jif.lower) && (jif.value <= jif.upper);
    end
endmodule

// ===== logic/discrete_io_ctrl.sv
// Discrete judgment outputs, control input decoding and APB registers
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module discrete_io_ctrl
    import discrete_io_pkg::*;
(
    input  wire logic                              mclk_i,
    input  wire logic                              sys_rst_i,
    // APB slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [7:0]                        paddr,
    input  wire logic [31:0]                       pwdata,
    output logic      [31:0]                       prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Measurement core
    input  wire logic signed [discrete_io_pkg::MEAS_W-1:0] meas_value_i,
    input  wire logic                              sensor_ok_i,
    input  wire logic                              head_present_i,
    input  wire logic [discrete_io_pkg::HEAD_W-1:0] head_id_i,
    // Discrete input pins
    input  wire logic                              trigger_or_bank_a_in_i,
    input  wire logic                              reset_or_bank_b_in_i,
    input  wire logic                              laser_disable_in_i,
    input  wire logic                              zero_offset_in_i,
    // Discrete output pins and indicators
    output logic                                   high_judgment_out_o,
    output logic                                   pass_judgment_out_o,
    output logic                                   low_judgment_out_o,
    output logic                                   measure_ready_out_o,
    output logic                                   ready_led_o,
    output logic                                   sampling_busy_out_o,
    output logic                                   laser_emit_o,
    output logic                                   light_error_o,
    output logic [1:0]                             bank_sel_o,
    output logic                                   settings_clear_o
);
    import discrete_io_pkg::*;

    // Conditioned inputs
    logic [NUM_IN-1:0] in_lvl, in_rise, in_fall;
    input_conditioner u_cond (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .raw_i     ({zero_offset_in_i, laser_disable_in_i,
                     reset_or_bank_b_in_i, trigger_or_bank_a_in_i}),
        .level_o   (in_lvl),
        .rise_o    (in_rise),
        .fall_o    (in_fall)
    );

    // Registers
    logic [CTRL_W-1:0]        ctrl_q, ctrl_d;
    logic signed [MEAS_W-1:0] upper_q, upper_d, lower_q, lower_d;
    logic                     head_chg_q, head_chg_d;
    logic                     head_known_q, head_known_d;
    logic [HEAD_W-1:0]        head_id_q, head_id_d;
    logic [31:0]              rdata_q, rdata_d;
    logic                     err_q, err_d;

    // Decoded modes
    logic bank_mode, hold_en, nm_keep;
    assign bank_mode = ctrl_q[CTRL_BANK_MODE_BIT];
    assign hold_en   = ctrl_q[CTRL_HOLD_EN_BIT];
    assign nm_keep   = ctrl_q[CTRL_NM_KEEP_BIT];

    // Pin roles depend on the assignment mode
    logic trig_rise, trig_fall, rst_in, rst_rise, laser_off, zero_rise;
    assign trig_rise = ~bank_mode & in_rise[IN_TRIG_BANK_A];
    assign trig_fall = ~bank_mode & in_fall[IN_TRIG_BANK_A];
    assign rst_in    = ~bank_mode & in_lvl[IN_RESET_BANK_B];
    assign rst_rise  = ~bank_mode & in_rise[IN_RESET_BANK_B];
    assign laser_off = in_lvl[IN_LASER_OFF];
    assign zero_rise = in_rise[IN_ZERO];

    // Head swap detection; a different id wipes the settings
    logic head_swap;
    assign head_swap = head_present_i & head_known_q & (head_id_i != head_id_q);

    // APB decode
    logic wr_en, rd_setup, addr_ok;
    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign addr_ok  = (paddr == CTRL_OFS) || (paddr == UPPER_OFS) ||
                      (paddr == LOWER_OFS) || (paddr == STATUS_OFS) ||
                      (paddr == HELD_OFS) || (paddr == ZERO_OFS);

    // Zero wait states: read data is captured in the setup cycle
    assign pready  = psel & penable;
    assign prdata  = rdata_q;
    assign pslverr = err_q;

    // Software settings and head tracking
    always_comb begin
        ctrl_d       = ctrl_q;
        upper_d      = upper_q;
        lower_d      = lower_q;
        head_known_d = head_known_q;
        head_id_d    = head_id_q;
        head_chg_d   = head_chg_q;
        if (wr_en && paddr == CTRL_OFS) begin
            ctrl_d = pwdata[CTRL_W-1:0];
        end
        if (wr_en && paddr == UPPER_OFS) begin
            upper_d = pwdata;
        end
        if (wr_en && paddr == LOWER_OFS) begin
            lower_d = pwdata;
        end
        // Write one to clear; a swap in the same cycle still sets
        if (wr_en && paddr == STATUS_OFS && pwdata[ST_HEAD_CHG_BIT]) begin
            head_chg_d = 1'b0;
        end
        if (head_present_i && !head_known_q) begin
            head_known_d = 1'b1;
            head_id_d    = head_id_i;
        end
        if (head_swap) begin
            ctrl_d     = CTRL_RST;
            upper_d    = UPPER_RST;
            lower_d    = LOWER_RST;
            head_id_d  = head_id_i;
            head_chg_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ctrl_q       <= CTRL_RST;
            upper_q      <= UPPER_RST;
            lower_q      <= LOWER_RST;
            head_known_q <= 1'b0;
            head_id_q    <= '0;
            head_chg_q   <= 1'b0;
        end else begin
            ctrl_q       <= ctrl_d;
            upper_q      <= upper_d;
            lower_q      <= lower_d;
            head_known_q <= head_known_d;
            head_id_q    <= head_id_d;
            head_chg_q   <= head_chg_d;
        end
    end

    // Hold sequencer: sampling window spans trigger high
    hold_state_t              hold_q, hold_d;
    logic signed [MEAS_W-1:0] held_q, held_d;
    always_comb begin
        hold_d = hold_q;
        held_d = held_q;
        unique case (hold_q)
            HOLD_IDLE: begin
                if (hold_en && trig_rise) begin
                    hold_d = HOLD_SAMPLE;
                end
            end
            HOLD_SAMPLE: begin
                if (trig_fall) begin
                    hold_d = HOLD_HELD;
                    held_d = meas_value_i;
                end
            end
            HOLD_HELD: begin
                if (trig_rise) begin
                    hold_d = HOLD_SAMPLE;
                end
            end
        endcase
        // Abort returns to live judgment, the state before holding
        if (rst_rise || rst_in || !hold_en || head_swap) begin
            hold_d = HOLD_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hold_q <= HOLD_IDLE;
            held_q <= '0;
        end else begin
            hold_q <= hold_d;
            held_q <= held_d;
        end
    end

    // Bank selection and switch busy timer
    logic [1:0]           bank_q, bank_d, bank_pins;
    logic [BANK_SW_W-1:0] bsw_cnt_q, bsw_cnt_d;
    assign bank_pins = {in_lvl[IN_RESET_BANK_B], in_lvl[IN_TRIG_BANK_A]};
    always_comb begin
        bank_d    = bank_q;
        bsw_cnt_d = bsw_cnt_q;
        if (bsw_cnt_q != '0) begin
            bsw_cnt_d = bsw_cnt_q - 1'b1;
        end
        // A new combination restarts the busy time
        if (bank_mode && bank_pins != bank_q) begin
            bank_d    = bank_pins;
            bsw_cnt_d = BANK_SW_CYCLES;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bank_q    <= 2'h0;
            bsw_cnt_q <= '0;
        end else begin
            bank_q    <= bank_d;
            bsw_cnt_q <= bsw_cnt_d;
        end
    end

    // Zero offset: one input edge executes, the next one clears
    logic                     zero_act_q, zero_act_d;
    logic signed [MEAS_W-1:0] zero_q, zero_d;
    always_comb begin
        zero_act_d = zero_act_q;
        zero_d     = zero_q;
        if (zero_rise) begin
            zero_act_d = ~zero_act_q;
            zero_d     = zero_act_q ? '0 : meas_value_i;
        end
        if (head_swap) begin
            zero_act_d = 1'b0;
            zero_d     = '0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            zero_act_q <= 1'b0;
            zero_q     <= '0;
        end else begin
            zero_act_q <= zero_act_d;
            zero_q     <= zero_d;
        end
    end

    // Comparator path
    judge_if jif ();
    threshold_judge u_judge (
        .jif (jif.cmp)
    );
    logic signed [MEAS_W-1:0] src_value;
    assign src_value = (hold_q == HOLD_HELD) ? held_q : meas_value_i;
    assign jif.value = MEAS_W'(src_value - zero_q);
    assign jif.upper = upper_q;
    assign jif.lower = lower_q;

    // Output stage; non-measurement either blanks or freezes judgments
    logic high_q, pass_q, low_q, ready_q, busy_q;
    logic high_d, pass_d, low_d, ready_d, busy_d;
    logic no_measure;
    assign no_measure = rst_in | laser_off;
    always_comb begin
        high_d = jif.high;
        pass_d = jif.pass;
        low_d  = jif.low;
        if (no_measure) begin
            high_d = nm_keep & high_q;
            pass_d = nm_keep & pass_q;
            low_d  = nm_keep & low_q;
        end
        if (rst_rise) begin
            high_d = 1'b0;
            pass_d = 1'b0;
            low_d  = 1'b0;
        end
        ready_d = head_present_i & sensor_ok_i & ~no_measure;
        busy_d  = (hold_d == HOLD_SAMPLE) | (bsw_cnt_d != '0);
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            high_q  <= 1'b0;
            pass_q  <= 1'b0;
            low_q   <= 1'b0;
            ready_q <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            high_q  <= high_d;
            pass_q  <= pass_d;
            low_q   <= low_d;
            ready_q <= ready_d;
            busy_q  <= busy_d;
        end
    end

    assign high_judgment_out_o = high_q;
    assign pass_judgment_out_o = pass_q;
    assign low_judgment_out_o  = low_q;
    assign measure_ready_out_o = ready_q;
    assign ready_led_o         = ready_q;
    assign sampling_busy_out_o = busy_q;
    assign bank_sel_o          = bank_q;
    // Laser control follows the synchronised pin directly
    assign laser_emit_o        = ~laser_off;
    assign light_error_o       = laser_off;
    assign settings_clear_o    = head_swap;

    // Read mux, captured in the setup cycle
    logic [31:0] status_w;
    always_comb begin
        status_w                  = '0;
        status_w[ST_HIGH_BIT]     = high_q;
        status_w[ST_PASS_BIT]     = pass_q;
        status_w[ST_LOW_BIT]      = low_q;
        status_w[ST_READY_BIT]    = ready_q;
        status_w[ST_BUSY_BIT]     = busy_q;
        status_w[ST_LIGHT_ERR]    = laser_off;
        status_w[ST_ZERO_ACT_BIT] = zero_act_q;
        status_w[ST_HOLD_VAL_BIT] = (hold_q == HOLD_HELD);
        status_w[ST_BANK_LSB+1:ST_BANK_LSB] = bank_q;
        status_w[ST_HEAD_CHG_BIT] = head_chg_q;
        rdata_d = rdata_q;
        err_d   = err_q;
        if (rd_setup) begin
            err_d = ~addr_ok;
            unique case (paddr)
                CTRL_OFS:   rdata_d = {{(32-CTRL_W){1'b0}}, ctrl_q};
                UPPER_OFS:  rdata_d = upper_q;
                LOWER_OFS:  rdata_d = lower_q;
                STATUS_OFS: rdata_d = status_w;
                HELD_OFS:   rdata_d = held_q;
                ZERO_OFS:   rdata_d = zero_q;
                default:    rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_q <= '0;
            err_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end
endmodule

// ===== bench/io_checker.sv
// Concurrent checks on the discrete I/O block ports
`timescale 1ns/1ps
module io_checker
    import discrete_io_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       sys_rst_i,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       laser_disable_in_i,
    input wire logic       high_judgment_out_o,
    input wire logic       pass_judgment_out_o,
    input wire logic       low_judgment_out_o,
    input wire logic       measure_ready_out_o,
    input wire logic       ready_led_o,
    input wire logic       sampling_busy_out_o,
    input wire logic       laser_emit_o,
    input wire logic       light_error_o,
    input wire logic [1:0] bank_sel_o,
    input wire logic       settings_clear_o
);
    // One clock domain, so clocking and disable are shared
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    a_pready_access: assert property (pready == (psel && penable))
        else $error("pready not tied to access phase");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
        else $error("unmapped access without slave error");
    a_judge_exclusive: assert property ($onehot0({high_judgment_out_o,
        pass_judgment_out_o, low_judgment_out_o}))
        else $error("two judgment outputs on together");
    a_ready_mirror: assert property (measure_ready_out_o == ready_led_o)
        else $error("ready output and indicator differ");
    a_laser_emit: assert property (laser_disable_in_i [*3] |-> !laser_emit_o)
        else $error("laser still emitting while held off");
    a_laser_err_rise: assert property ($rose(laser_disable_in_i) |->
        ##[1:3] light_error_o) else $error("light error late after laser off");
    a_laser_ready: assert property (laser_disable_in_i [*5] |->
        !measure_ready_out_o) else $error("ready while laser held off");
    a_laser_freeze: assert property (laser_disable_in_i [*5] |->
        $stable({high_judgment_out_o, pass_judgment_out_o, low_judgment_out_o}))
        else $error("judgments moved while laser held off");
    a_bank_busy: assert property ($changed(bank_sel_o) |->
        ##[0:2] sampling_busy_out_o) else $error("bank switch without busy");
    a_clear_pulse: assert property (settings_clear_o |=> !settings_clear_o)
        else $error("settings clear longer than one cycle");
endmodule
bind discrete_io_ctrl io_checker chk_u (.mclk_i, .sys_rst_i, .psel, .penable,
    .paddr, .pready, .pslverr, .laser_disable_in_i, .high_judgment_out_o,
    .pass_judgment_out_o, .low_judgment_out_o, .measure_ready_out_o, .ready_led_o,
    .sampling_busy_out_o, .laser_emit_o, .light_error_o, .bank_sel_o,
    .settings_clear_o);

// ===== bench/pin_partner.sv
// Model of the external controller wired to the four discrete inputs
`timescale 1ns/1ps
module pin_partner (
    input  wire logic       mclk_i,
    input  wire logic [3:0] want_i,
    input  wire logic       bank_en_i,
    input  wire logic [1:0] bank_i,
    output logic      [3:0] pins_o
);
    // Pins change only after an edge; bank number goes out as levels on A and B
    // A single driver of the lines; they settle at the first edge, inside reset
    always @(posedge mclk_i) begin
        pins_o[3:2] <= want_i[3:2];
        pins_o[1:0] <= bank_en_i ? bank_i : want_i[1:0];
    end
endmodule

// ===== bench/discrete_io_ctrl_test.sv
// Self-checking bench for the discrete I/O block
`timescale 1ns/1ps
module discrete_io_ctrl_test;
    import discrete_io_pkg::*;
    logic                     mclk_i = 1'b0;
    logic                     sys_rst_i = 1'b1;
    logic                     psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]               paddr = 8'h00;
    logic [31:0]              pwdata = 32'h0000_0000, prdata, rd;
    logic                     pready, pslverr, err, hi, ps, lo, rdy, led, busy;
    logic                     emit, lerr, sclr, bank_en = 1'b0;
    logic                     sensor_ok = 1'b1, present = 1'b1;
    logic signed [MEAS_W-1:0] meas = 32'h0000_0000;
    logic [HEAD_W-1:0]        head_id = 8'h5a;
    logic [3:0]               want = 4'h0, pins;
    logic [1:0]               bank = 2'h0, bank_sel;
    int                       errors = 0, samples_checked = 0, seed = 32'hc43a, n;
    int                       corner[4] = '{100, 101, -100, -101};

    // 200 MHz clock
    always #2.5 mclk_i = ~mclk_i;

    discrete_io_ctrl dut_u (.mclk_i, .sys_rst_i, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .meas_value_i(meas), .sensor_ok_i(sensor_ok),
        .head_present_i(present), .head_id_i(head_id), .trigger_or_bank_a_in_i(pins[0]),
        .reset_or_bank_b_in_i(pins[1]), .laser_disable_in_i(pins[2]),
        .zero_offset_in_i(pins[3]), .high_judgment_out_o(hi), .pass_judgment_out_o(ps),
        .low_judgment_out_o(lo), .measure_ready_out_o(rdy), .ready_led_o(led),
        .sampling_busy_out_o(busy), .laser_emit_o(emit), .light_error_o(lerr),
        .bank_sel_o(bank_sel), .settings_clear_o(sclr));
    pin_partner pin_u (.mclk_i, .want_i(want), .bank_en_i(bank_en), .bank_i(bank),
        .pins_o(pins));

    // Compare and count
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic tick(int c);
        repeat (c) @(posedge mclk_i);
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        n = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            n++;
        end
        if (n == 20) begin
            errors++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected {high, pass, low} for a judged value
    function automatic logic [2:0] judge(int v, int u, int l);
        return {v > u, v >= l && v <= u, v < l};
    endfunction
    task automatic setv(int v);
        meas <= v;
        tick(5);
    endtask
    task automatic pulse(int i);
        want[i] <= 1'b1;
        tick(6);
        want[i] <= 1'b0;
        tick(6);
    endtask

    initial begin
        tick(5);
        sys_rst_i <= 1'b0;
        apb(1'b0, CTRL_OFS, 0);
        check("ctrl reset", rd, 32'h0000_0000);
        apb(1'b0, UPPER_OFS, 0);
        check("upper reset", rd, UPPER_RST);
        apb(1'b0, LOWER_OFS, 0);
        check("lower reset", rd, LOWER_RST);
        apb(1'b0, 8'h18, 0);
        check("unmapped error", err, 1);
        apb(1'b1, UPPER_OFS, 32'h0000_0064);
        apb(1'b1, LOWER_OFS, 32'hffff_ff9c);
        // Limits themselves, one past each, then random values near the window
        for (int i = 0; i < 16; i++) begin
            setv(i < 4 ? corner[i] : $random(seed) % 160);
            check("judgment", {hi, ps, lo}, judge(meas, 100, -100));
        end
        check("ready and led", {rdy, led}, 2'b11);
        // Ready needs a working core and an attached head
        sensor_ok <= 1'b0;
        tick(2);
        check("ready without sensor", {rdy, led}, 2'b00);
        sensor_ok <= 1'b1;
        present <= 1'b0;
        tick(2);
        check("ready without head", {rdy, led}, 2'b00);
        present <= 1'b1;
        tick(2);
        setv(50);
        pulse(3);
        setv(150);
        check("zero applied", {hi, ps, lo}, 3'b010);
        setv(-60);
        check("zero applied low", {hi, ps, lo}, 3'b001);
        apb(1'b0, ZERO_OFS, 0);
        check("zero offset", rd, 32'h0000_0032);
        pulse(3);
        check("zero cleared", {hi, ps, lo}, 3'b010);
        // Laser off with last judgments kept
        apb(1'b1, CTRL_OFS, 32'h0000_0004);
        setv(500);
        want[2] <= 1'b1;
        tick(6);
        check("laser off", {emit, lerr, rdy}, 3'b010);
        setv(-500);
        check("kept judgment", {hi, ps, lo}, 3'b100);
        want[2] <= 1'b0;
        tick(6);
        check("laser back", {rdy, hi, ps, lo}, 4'b1001);
        // Reset input with judgments off while held
        apb(1'b1, CTRL_OFS, 32'h0000_0002);
        want[1] <= 1'b1;
        setv(0);
        setv(500);
        check("reset held", {rdy, hi, ps, lo}, 4'b0000);
        want[1] <= 1'b0;
        setv(-20);
        want[0] <= 1'b1;
        tick(6);
        check("sampling busy", busy, 1);
        want[0] <= 1'b0;
        tick(6);
        check("busy ends", busy, 0);
        setv(500);
        check("held value", {hi, ps, lo}, 3'b010);
        apb(1'b0, HELD_OFS, 0);
        check("held register", rd, 32'hffff_ffec);
        pulse(1);
        check("reset drops hold", {hi, ps, lo}, 3'b100);
        // Bank numbers 1 to 3; B high must not act as reset here
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        bank_en <= 1'b1;
        for (int b = 1; b < 4; b++) begin
            bank <= b[1:0];
            tick(6);
            check("bank index", bank_sel, b);
            check("bank busy", {busy, rdy}, 2'b11);
            tick(180);
            check("bank busy long", busy, 1);
            tick(30);
            check("bank busy over", busy, 0);
        end
        bank_en <= 1'b0;
        head_id <= 8'ha5;
        n = 0;
        while (sclr !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        check("settings clear", n < 10, 1);
        tick(2);
        apb(1'b0, UPPER_OFS, 0);
        check("upper cleared", rd, UPPER_RST);
        // Head changed flag stands until software writes one to it
        apb(1'b0, STATUS_OFS, 0);
        check("head changed set", rd[ST_HEAD_CHG_BIT], 1);
        apb(1'b1, STATUS_OFS, 32'h0000_0400);
        apb(1'b0, STATUS_OFS, 0);
        check("head changed clear", rd[ST_HEAD_CHG_BIT], 0);
        results();
    end
endmodule
